// File: csr_alu_model.sv
// far-side adder model that feeds result flags into the core state block
`timescale 1ns/10ps
`default_nettype none
module csr_alu_model (
  // operands
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  // result flags
  output logic            c_o,
  output logic            z_o,
  output logic            n_o,
  output logic            v_o,
  output logic            h_o
);
  logic [8:0] sum;
  logic [4:0] low;
  always_comb begin
    sum = {1'b0, a_i} + {1'b0, b_i};
    low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
    c_o = sum[8];
    z_o = (sum[7:0] == 8'h00);
    n_o = sum[7];
    v_o = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
    h_o = low[4];
  end
endmodule
`default_nettype wire

// File: csr_core_state.sv
// top: status flags, register file and stack pointer of the core
// Overview of operation
// RULE1: status flags update after every alu operation
// RULE2: status flags are never saved or restored on interrupt entry or return
// RULE3: bit 7 is global interrupt enable; clear blocks every interrupt
// RULE4: taking an interrupt clears bit 7; interrupt return sets it
// RULE5: set and clear interrupt instructions write bit 7 directly
// RULE6: bit 6 is the bit transfer flag for bit store and bit load
// RULE7: bit 5 holds the half carry from the low nibble
// RULE8: bit 4 always equals negative xor overflow; the code recomputes it only on alu updates with alu_mask_i bit 4 set
// RULE9: bit 3 holds two's complement overflow
// RULE10: bits 2,1,0 hold negative, zero and carry of latest result
// RULE11: status flags read/write at i/o 0x3f (data 0x5f), reset zero
// RULE12: register file: 32 bytes, byte and word read and write-back patterns
// RULE13: each register also sits at data address equal to its index
// RULE14: registers 26..31 form three 16-bit pointers, low byte even
// RULE15: pointers support displacement, post-increment and pre-decrement
// RULE16: stack grows downward; pointer marks top of stack
// RULE17: byte push decrements by 1, byte pop increments by 1
// RULE18: calls and interrupt entry decrement by 2, returns increment by 2
// RULE19: stack pointer resets to last data memory address
// RULE20: stack pointer bytes at i/o 0x3e high and 0x3d low
// RULE21: software sets a valid stack pointer before calls or interrupts
// RULE22: after interrupt return one instruction runs before next interrupt
// RULE23: push writes at pointer then decrements; pop increments then reads
`timescale 1ns/10ps
`default_nettype none
module csr_core_state
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // alu result flags
  input  wire logic          alu_upd_i,
  input  wire logic [7:0]    alu_mask_i,
  input  wire logic          alu_c_i,
  input  wire logic          alu_z_i,
  input  wire logic          alu_n_i,
  input  wire logic          alu_v_i,
  input  wire logic          alu_h_i,
  // bit transfer
  input  wire logic          bit_store_instruction_i,
  input  wire logic          bit_load_instruction_i,
  input  wire logic [2:0]    bit_sel_i,
  input  wire logic [4:0]    bit_reg_i,
  // interrupt enable control
  input  wire csr_ien_cmd_t  ien_cmd_i,
  input  wire logic          instr_done_i,
  input  wire logic          irq_pending_i,
  output logic               irq_take_ok_o,
  output logic               global_ien_o,
  // register file operands
  input  wire logic [4:0]    rd_a_idx_i,
  input  wire logic [4:0]    rd_b_idx_i,
  output logic      [7:0]    rd_a_o,
  output logic      [7:0]    rd_b_o,
  output logic      [15:0]   rd_word_o,
  input  wire logic          wr8_en_i,
  input  wire logic          wr16_en_i,
  input  wire logic [4:0]    wr_idx_i,
  input  wire logic [15:0]   wr_data_i,
  // indirect pointer access
  input  wire logic          ptr_en_i,
  input  wire logic [4:0]    ptr_sel_i,
  input  wire csr_ptr_mode_t ptr_mode_i,
  input  wire logic [5:0]    ptr_disp_i,
  output logic      [15:0]   ptr_addr_o,
  // stack
  input  wire csr_stk_op_t   stk_op_i,
  output logic      [15:0]   stk_addr_o,
  output logic      [15:0]   sp_o,
  // i/o space access
  input  wire logic          io_wr_i,
  input  wire logic [5:0]    io_addr_i,
  input  wire logic [7:0]    io_wdata_i,
  output logic      [7:0]    io_rdata_o,
  output logic               io_hit_o,
  // data space access
  input  wire logic          ds_wr_i,
  input  wire logic [15:0]   ds_addr_i,
  input  wire logic [7:0]    ds_wdata_i,
  output logic      [7:0]    ds_rdata_o,
  output logic               ds_hit_o,
  // status flags view
  output logic      [7:0]    status_flags_o
);
  logic [7:0]  status_flags;
  logic [7:0]  next_status_flags;
  logic        ret_hold;
  logic        next_ret_hold;
  logic [7:0]  rf_a;
  logic [7:0]  rf_ds_rdata;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_new;
  logic        ptr_wr;
  logic        sp_wr_low;
  logic        sp_wr_high;
  logic        sr_wr;
  logic        rf_ds_wr;
  logic        rf_bit_wr;
  logic [7:0]  bit_wdata;
  logic [5:0]  ds_io_addr;
  logic        ds_io_sel;
  logic        ds_rf_sel;
  logic [7:0]  io_read;

  // map a data-space address onto the i/o window
  function automatic logic [5:0] io_of_ds(input logic [15:0] a);
    logic [15:0] d;
    d = a - IO_DATA_BASE;
    io_of_ds = d[5:0];
  endfunction

  function automatic logic [7:0] io_reg_read(input logic [5:0] a, input logic [7:0] sr,
                                             input logic [15:0] sp);
    io_reg_read = 8'h00;
    if (a == IO_STATUS_FLAGS)       io_reg_read = sr;
    if (a == IO_STACK_POINTER_HIGH) io_reg_read = sp[15:8];
    if (a == IO_STACK_POINTER_LOW)  io_reg_read = sp[7:0];
  endfunction

  // address decode
  assign ds_rf_sel  = (ds_addr_i <= REGFILE_TOP); // RULE13
  assign ds_io_sel  = (ds_addr_i >= IO_DATA_BASE) && (ds_addr_i < (IO_DATA_BASE + 16'h0040));
  assign ds_io_addr = io_of_ds(ds_addr_i);
  assign rf_ds_wr   = ds_wr_i && ds_rf_sel;
  assign sr_wr      = (io_wr_i && io_addr_i == IO_STATUS_FLAGS)
                   || (ds_wr_i && ds_io_sel && ds_io_addr == IO_STATUS_FLAGS); // RULE11
  assign sp_wr_low  = (io_wr_i && io_addr_i == IO_STACK_POINTER_LOW)
                   || (ds_wr_i && ds_io_sel && ds_io_addr == IO_STACK_POINTER_LOW); // RULE20
  assign sp_wr_high = (io_wr_i && io_addr_i == IO_STACK_POINTER_HIGH)
                   || (ds_wr_i && ds_io_sel && ds_io_addr == IO_STACK_POINTER_HIGH); // RULE20
  assign io_hit_o   = (io_addr_i == IO_STATUS_FLAGS) || (io_addr_i == IO_STACK_POINTER_HIGH)
                   || (io_addr_i == IO_STACK_POINTER_LOW);
  assign io_read    = io_reg_read(ds_io_addr, status_flags, sp_o);
  assign ds_hit_o   = ds_rf_sel || (ds_io_sel && (ds_io_addr == IO_STATUS_FLAGS
                   || ds_io_addr == IO_STACK_POINTER_HIGH || ds_io_addr == IO_STACK_POINTER_LOW));

  // pointer address unit: any register pair, selected by index bits 4..1
  always_comb begin
    ptr_new    = ptr_cur;
    ptr_addr_o = ptr_cur;
    ptr_wr     = 1'b0;
    if (ptr_en_i) begin
      unique case (ptr_mode_i)
        CSR_PTR_DISP:    ptr_addr_o = ptr_cur + {10'h000, ptr_disp_i}; // RULE15
        CSR_PTR_POSTINC: begin
          ptr_new = ptr_cur + STEP_ONE; // RULE15
          ptr_wr  = 1'b1;
        end
        CSR_PTR_PREDEC: begin
          ptr_new    = ptr_cur - STEP_ONE; // RULE15
          ptr_addr_o = ptr_new;
          ptr_wr     = 1'b1;
        end
        default: ptr_addr_o = ptr_cur;
      endcase
    end
  end

  // bit load overwrites one bit of the chosen register with the transfer flag
  assign rf_bit_wr = bit_load_instruction_i;
  always_comb begin
    bit_wdata = rd_b_o;
    bit_wdata[bit_sel_i] = status_flags[FLAG_T]; // RULE6
  end

  csr_regfile u_regfile (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .rd_a_idx_i (rd_a_idx_i),
    .rd_b_idx_i (bit_load_instruction_i || bit_store_instruction_i ? bit_reg_i : rd_b_idx_i),
    .rd_a_o     (rf_a),
    .rd_b_o     (rd_b_o),
    .rd_word_o  (rd_word_o),
    .wr8_en_i   (wr8_en_i || rf_bit_wr),
    .wr16_en_i  (wr16_en_i && !rf_bit_wr),
    .wr_idx_i   (rf_bit_wr ? bit_reg_i : wr_idx_i),
    .wr_data_i  (rf_bit_wr ? {8'h00, bit_wdata} : wr_data_i),
    .ptr_wr_i   (ptr_wr),
    .ptr_idx_i  (ptr_sel_i),
    .ptr_val_i  (ptr_new),
    .ds_wr_i    (rf_ds_wr),
    .ds_idx_i   (ds_addr_i[4:0]),
    .ds_wdata_i (ds_wdata_i),
    .ds_rdata_o (rf_ds_rdata)
  );

  // pointer pair is peeked from the array; both read ports stay free for operands
  assign ptr_cur = {u_regfile.regs[{ptr_sel_i[4:1], 1'b1}],
                    u_regfile.regs[{ptr_sel_i[4:1], 1'b0}]}; // RULE14
  assign rd_a_o   = rf_a;

  csr_stack u_stack (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .op_i      (stk_op_i),
    .addr_o    (stk_addr_o),
    .wr_low_i  (sp_wr_low),
    .wr_high_i (sp_wr_high),
    .wdata_i   (sp_wr_low || sp_wr_high ? (io_wr_i ? io_wdata_i : ds_wdata_i) : 8'h00),
    .sp_o      (sp_o)
  );

  // status flags next value; explicit write first, hardware events after it
  always_comb begin
    next_status_flags = status_flags;
    next_ret_hold     = ret_hold;
    if (sr_wr) begin
      next_status_flags = io_wr_i ? io_wdata_i : ds_wdata_i; // RULE11
    end
    if (alu_upd_i) begin // RULE1
      if (alu_mask_i[FLAG_C]) next_status_flags[FLAG_C] = alu_c_i; // RULE10
      if (alu_mask_i[FLAG_Z]) next_status_flags[FLAG_Z] = alu_z_i; // RULE10
      if (alu_mask_i[FLAG_N]) next_status_flags[FLAG_N] = alu_n_i; // RULE10
      if (alu_mask_i[FLAG_V]) next_status_flags[FLAG_V] = alu_v_i; // RULE9
      if (alu_mask_i[FLAG_H]) next_status_flags[FLAG_H] = alu_h_i; // RULE7
      if (alu_mask_i[FLAG_S]) begin
        next_status_flags[FLAG_S] = next_status_flags[FLAG_N]
                                  ^ next_status_flags[FLAG_V]; // RULE8
      end
    end
    if (bit_store_instruction_i) begin
      next_status_flags[FLAG_T] = rd_b_o[bit_sel_i]; // RULE6
    end
    // entry and return leave the other flags untouched
    unique case (ien_cmd_i)
      CSR_IEN_NONE:   next_status_flags[FLAG_I] = next_status_flags[FLAG_I]; // RULE2
      CSR_IEN_SET:    next_status_flags[FLAG_I] = 1'b1; // RULE5
      CSR_IEN_CLEAR:  next_status_flags[FLAG_I] = 1'b0; // RULE5
      CSR_IEN_TAKE:   next_status_flags[FLAG_I] = 1'b0; // RULE4
      CSR_IEN_RETURN: begin
        next_status_flags[FLAG_I] = 1'b1; // RULE4
        next_ret_hold = 1'b1; // RULE22
      end
      default: next_status_flags[FLAG_I] = next_status_flags[FLAG_I];
    endcase
    if (instr_done_i && ien_cmd_i != CSR_IEN_RETURN) begin
      next_ret_hold = 1'b0; // RULE22
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_flags <= STATUS_RESET; // RULE11
      ret_hold     <= 1'b0;
    end else begin
      status_flags <= next_status_flags;
      ret_hold     <= next_ret_hold;
    end
  end

  // clear-interrupts takes effect at once, also against a same-cycle request
  assign irq_take_ok_o  = irq_pending_i && status_flags[FLAG_I] && !ret_hold
                       && ien_cmd_i != CSR_IEN_CLEAR; // RULE3
  assign global_ien_o   = status_flags[FLAG_I]; // RULE3
  assign status_flags_o = status_flags;
  assign io_rdata_o     = io_reg_read(io_addr_i, status_flags, sp_o);
  assign ds_rdata_o     = ds_rf_sel ? rf_ds_rdata : (ds_io_sel ? io_read : 8'h00);
endmodule
`default_nettype wire

// File: csr_core_state_monitor.sv
// concurrent checks on the ports of the core state block
`timescale 1ns/10ps
`default_nettype none
module csr_core_state_monitor
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // watched ports
  input  wire csr_ien_cmd_t ien_cmd_i,
  input  wire logic         instr_done_i,
  input  wire logic         irq_pending_i,
  input  wire logic         irq_take_ok_o,
  input  wire logic         global_ien_o,
  input  wire logic         alu_upd_i,
  input  wire logic [7:0]   alu_mask_i,
  input  wire csr_stk_op_t  stk_op_i,
  input  wire logic [15:0]  stk_addr_o,
  input  wire logic [15:0]  sp_o,
  input  wire logic         io_wr_i,
  input  wire logic [5:0]   io_addr_i,
  input  wire logic [7:0]   io_rdata_o,
  input  wire logic [7:0]   status_flags_o,
  input  wire logic [4:0]   rd_a_idx_i,
  input  wire logic [7:0]   rd_a_o,
  input  wire logic [15:0]  ds_addr_i,
  input  wire logic [7:0]   ds_rdata_o,
  input  wire logic         ds_hit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_ret;
    ien_cmd_i == CSR_IEN_RETURN && !io_wr_i;
  endsequence
  sequence s_done_quiet;
    instr_done_i && ien_cmd_i == CSR_IEN_NONE && !io_wr_i && !alu_upd_i;
  endsequence
  property p_ien_gate; !global_ien_o |-> !irq_take_ok_o; endproperty
  property p_sign;
    alu_upd_i && (&alu_mask_i[4:2]) && !io_wr_i
      |=> status_flags_o[4] == (status_flags_o[2] ^ status_flags_o[3]);
  endproperty
  property p_push1;
    stk_op_i == CSR_STK_PUSH1 && !io_wr_i
      |-> stk_addr_o == sp_o ##1 sp_o == $past(sp_o) - 16'h0001;
  endproperty
  property p_pop1;
    stk_op_i == CSR_STK_POP1 && !io_wr_i
      |-> stk_addr_o == sp_o + 16'h0001 ##1 sp_o == $past(sp_o) + 16'h0001;
  endproperty
  property p_push2;
    stk_op_i == CSR_STK_PUSH2 && !io_wr_i |=> sp_o == $past(sp_o) - 16'h0002;
  endproperty
  property p_take; ien_cmd_i == CSR_IEN_TAKE && !io_wr_i |=> !global_ien_o; endproperty
  property p_ret_hold; s_ret |=> !irq_take_ok_o; endproperty
  property p_ret_release;
    s_ret ##1 s_done_quiet ##1 (irq_pending_i && ien_cmd_i != CSR_IEN_CLEAR)
      |-> irq_take_ok_o;
  endproperty
  property p_clear;
    ien_cmd_i == CSR_IEN_CLEAR && !io_wr_i |-> !irq_take_ok_o ##1 !global_ien_o;
  endproperty
  property p_io_flags; io_addr_i == IO_STATUS_FLAGS |-> io_rdata_o == status_flags_o; endproperty
  property p_io_sp; io_addr_i == IO_STACK_POINTER_HIGH |-> io_rdata_o == sp_o[15:8]; endproperty
  property p_ds_reg;
    ds_addr_i[15:5] == 11'h000 && rd_a_idx_i == ds_addr_i[4:0]
      |-> ds_hit_o && ds_rdata_o == rd_a_o;
  endproperty
  a_ien_gate:
    assert property (p_ien_gate) else $error("interrupt allowed while disabled");
  a_sign:
    assert property (p_sign) else $error("sign flag differs from n xor v");
  a_push1:
    assert property (p_push1) else $error("byte push address or step wrong");
  a_pop1:
    assert property (p_pop1) else $error("byte pop address or step wrong");
  a_push2:
    assert property (p_push2) else $error("word push step wrong");
  a_take:
    assert property (p_take) else $error("enable kept after interrupt taken");
  a_ret_hold:
    assert property (p_ret_hold) else $error("interrupt allowed right after return");
  a_ret_release:
    assert property (p_ret_release) else $error("interrupt held after one instruction");
  a_clear:
    assert property (p_clear) else $error("clear did not block interrupts");
  a_io_flags:
    assert property (p_io_flags) else $error("flag read mismatch");
  a_io_sp:
    assert property (p_io_sp) else $error("stack high byte read mismatch");
  a_ds_reg:
    assert property (p_ds_reg) else $error("register mirror read mismatch");
endmodule
bind csr_core_state csr_core_state_monitor mon_u (.clk_i, .resetn_i, .ien_cmd_i,
  .instr_done_i, .irq_pending_i, .irq_take_ok_o, .global_ien_o, .alu_upd_i, .alu_mask_i,
  .stk_op_i, .stk_addr_o, .sp_o, .io_wr_i, .io_addr_i, .io_rdata_o, .status_flags_o,
  .rd_a_idx_i, .rd_a_o, .ds_addr_i, .ds_rdata_o, .ds_hit_o);
`default_nettype wire

// File: csr_pkg.sv
// package: constants and types for the core state block
package csr_pkg;
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  // i/o space offsets and data-space mirror base
  localparam logic [5:0] IO_STACK_POINTER_LOW  = 6'h3d;
  localparam logic [5:0] IO_STACK_POINTER_HIGH = 6'h3e;
  localparam logic [5:0] IO_STATUS_FLAGS       = 6'h3f;
  localparam logic [15:0] IO_DATA_BASE         = 16'h0020;
  localparam logic [15:0] REGFILE_TOP          = 16'h001f;
  localparam logic [7:0]  STATUS_RESET         = 8'h00;
  // last internal data memory address, stack pointer reset value
  localparam logic [15:0] LAST_DATA_MEMORY_ADDRESS = 16'h08ff;
  // pointer pair low-byte indices
  localparam logic [4:0] PTR_X_LOW = 5'h1a;
  localparam logic [4:0] PTR_Y_LOW = 5'h1c;
  localparam logic [4:0] PTR_Z_LOW = 5'h1e;
  // stack operations
  typedef enum logic [2:0] {
    CSR_STK_NONE, CSR_STK_PUSH1, CSR_STK_POP1, CSR_STK_PUSH2, CSR_STK_POP2
  } csr_stk_op_t;
  // pointer addressing modes
  typedef enum logic [1:0] {
    CSR_PTR_DISP, CSR_PTR_POSTINC, CSR_PTR_PREDEC
  } csr_ptr_mode_t;
  // interrupt-enable commands
  typedef enum logic [2:0] {
    CSR_IEN_NONE, CSR_IEN_SET, CSR_IEN_CLEAR, CSR_IEN_TAKE, CSR_IEN_RETURN
  } csr_ien_cmd_t;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
endpackage

// File: csr_regfile.sv
// 32 x 8 general register file with a pointer update port for the address unit
`timescale 1ns/10ps
`default_nettype none
module csr_regfile
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // operand reads
  input  wire logic [4:0]    rd_a_idx_i,
  input  wire logic [4:0]    rd_b_idx_i,
  output logic      [7:0]    rd_a_o,
  output logic      [7:0]    rd_b_o,
  output logic      [15:0]   rd_word_o,
  // result write-back
  input  wire logic          wr8_en_i,
  input  wire logic          wr16_en_i,
  input  wire logic [4:0]    wr_idx_i,
  input  wire logic [15:0]   wr_data_i,
  // pointer update from address unit
  input  wire logic          ptr_wr_i,
  input  wire logic [4:0]    ptr_idx_i,
  input  wire logic [15:0]   ptr_val_i,
  // data-space byte access
  input  wire logic          ds_wr_i,
  input  wire logic [4:0]    ds_idx_i,
  input  wire logic [7:0]    ds_wdata_i,
  output logic      [7:0]    ds_rdata_o
);
  logic [7:0] regs [32];
  logic [7:0] next_regs [32];

  function automatic logic [4:0] pair_hi(input logic [4:0] idx);
    pair_hi = {idx[4:1], 1'b1};
  endfunction

  // reads: two byte operands, one word operand on an even pair
  assign rd_a_o     = regs[rd_a_idx_i];
  assign rd_b_o     = regs[rd_b_idx_i];
  assign rd_word_o  = {regs[pair_hi(rd_a_idx_i)], regs[{rd_a_idx_i[4:1], 1'b0}]}; // RULE12
  assign ds_rdata_o = regs[ds_idx_i]; // RULE13

  // later writes win: pointer update after result, data store last
  always_comb begin
    next_regs = regs;
    if (wr8_en_i) begin
      next_regs[wr_idx_i] = wr_data_i[7:0]; // RULE12
    end
    if (wr16_en_i) begin
      next_regs[{wr_idx_i[4:1], 1'b0}] = wr_data_i[7:0]; // RULE12
      next_regs[pair_hi(wr_idx_i)]     = wr_data_i[15:8];
    end
    if (ptr_wr_i) begin
      next_regs[{ptr_idx_i[4:1], 1'b0}] = ptr_val_i[7:0]; // RULE14
      next_regs[pair_hi(ptr_idx_i)]     = ptr_val_i[15:8];
    end
    if (ds_wr_i) begin
      next_regs[ds_idx_i] = ds_wdata_i; // RULE13
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      regs <= next_regs;
    end
  end
endmodule
`default_nettype wire

// File: csr_stack.sv
// stack pointer with push/pop stepping and i/o byte access
`timescale 1ns/10ps
`default_nettype none
module csr_stack
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // stack operation
  input  wire csr_stk_op_t   op_i,
  output logic      [15:0]  addr_o,
  // i/o byte writes
  input  wire logic          wr_low_i,
  input  wire logic          wr_high_i,
  input  wire logic [7:0]    wdata_i,
  // current value
  output logic      [15:0]  sp_o
);
  logic [15:0] sp;
  logic [15:0] next_sp;

  // push uses the pointer then decrements; pop increments then uses it
  always_comb begin
    next_sp = sp;
    addr_o  = sp;
    unique case (op_i)
      CSR_STK_NONE:  next_sp = sp;
      CSR_STK_PUSH1: next_sp = sp - STEP_ONE; // RULE17
      CSR_STK_POP1: begin
        next_sp = sp + STEP_ONE; // RULE17
        addr_o  = next_sp; // RULE23
      end
      CSR_STK_PUSH2: next_sp = sp - STEP_TWO; // RULE18
      CSR_STK_POP2: begin
        next_sp = sp + STEP_TWO; // RULE18
        addr_o  = sp + STEP_ONE; // RULE23
      end
      default: next_sp = sp;
    endcase
    if (wr_low_i) begin
      next_sp[7:0] = wdata_i; // RULE20
    end
    if (wr_high_i) begin
      next_sp[15:8] = wdata_i; // RULE20
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp <= LAST_DATA_MEMORY_ADDRESS; // RULE19
    end else begin
      sp <= next_sp; // RULE16
    end
  end

  assign sp_o = sp;
endmodule
`default_nettype wire

// File: tb.sv
// self-checking testbench for the core state block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb
  import csr_pkg::*;
;
  logic          clk_i;
  logic          resetn_i = 1'b0;
  logic [7:0]    op_a = 8'h00, op_b = 8'h00, alu_mask_i = 8'h00;
  logic          alu_upd_i = 0, alu_c_i, alu_z_i, alu_n_i, alu_v_i, alu_h_i;
  logic          bit_store_instruction_i = 0, bit_load_instruction_i = 0;
  logic [2:0]    bit_sel_i = 3'h0;
  logic [4:0]    bit_reg_i = 5'h00, rd_a_idx_i = 5'h00, rd_b_idx_i = 5'h00;
  logic [4:0]    wr_idx_i = 5'h00, ptr_sel_i = 5'h1a;
  csr_ien_cmd_t  ien_cmd_i = CSR_IEN_NONE;
  logic          instr_done_i = 0, irq_pending_i = 0, wr8_en_i = 0, wr16_en_i = 0;
  logic [15:0]   wr_data_i = 16'h0000, ds_addr_i = 16'h0000;
  logic          ptr_en_i = 0, io_wr_i = 0, ds_wr_i = 0;
  csr_ptr_mode_t ptr_mode_i = CSR_PTR_DISP;
  logic [5:0]    ptr_disp_i = 6'h00, io_addr_i = 6'h00;
  csr_stk_op_t   stk_op_i = CSR_STK_NONE;
  logic [7:0]    io_wdata_i = 8'h00, ds_wdata_i = 8'h00;
  logic          irq_take_ok_o, global_ien_o, io_hit_o, ds_hit_o;
  logic [7:0]    rd_a_o, rd_b_o, io_rdata_o, ds_rdata_o, status_flags_o;
  logic [15:0]   rd_word_o, ptr_addr_o, stk_addr_o, sp_o;
  int            errors = 0, n_tests = 0, seed = 19;
  logic [7:0]    mem [32];
  csr_ien_cmd_t  cmds [4] = '{CSR_IEN_SET, CSR_IEN_TAKE, CSR_IEN_RETURN, CSR_IEN_CLEAR};
  csr_stk_op_t   sops [4] = '{CSR_STK_PUSH1, CSR_STK_PUSH2, CSR_STK_POP2, CSR_STK_POP1};
  logic [15:0]   sdel [4] = '{16'hffff, 16'hfffe, 16'h0002, 16'h0001};

  csr_alu_model alu_u (.a_i(op_a), .b_i(op_b), .c_o(alu_c_i), .z_o(alu_z_i), .n_o(alu_n_i),
                       .v_o(alu_v_i), .h_o(alu_h_i));
  csr_core_state dut_u (.clk_i, .resetn_i, .alu_upd_i, .alu_mask_i, .alu_c_i, .alu_z_i,
    .alu_n_i, .alu_v_i, .alu_h_i, .bit_store_instruction_i, .bit_load_instruction_i,
    .bit_sel_i, .bit_reg_i, .ien_cmd_i, .instr_done_i, .irq_pending_i, .irq_take_ok_o,
    .global_ien_o, .rd_a_idx_i, .rd_b_idx_i, .rd_a_o, .rd_b_o, .rd_word_o, .wr8_en_i,
    .wr16_en_i, .wr_idx_i, .wr_data_i, .ptr_en_i, .ptr_sel_i, .ptr_mode_i, .ptr_disp_i,
    .ptr_addr_o, .stk_op_i, .stk_addr_o, .sp_o, .io_wr_i, .io_addr_i, .io_wdata_i,
    .io_rdata_o, .io_hit_o, .ds_wr_i, .ds_addr_i, .ds_wdata_i, .ds_rdata_o, .ds_hit_o,
    .status_flags_o);

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [7:0] exp_flags(input logic [7:0] old, input logic [7:0] m,
                                           input logic [4:0] hvnzc);
    logic [7:0] f;
    f = (old & ~m) | (m & {2'b00, hvnzc[4], 1'b0, hvnzc[3:0]});
    if (m[4]) begin
      f[4] = f[2] ^ f[3];
    end
    return f;
  endfunction

  // one edge takes the request, a second edge passes so no strobe is re-raised in one step
  task automatic fire();
    @(posedge clk_i);
    #1;
    {alu_upd_i, bit_store_instruction_i, bit_load_instruction_i, instr_done_i, wr8_en_i,
     wr16_en_i, ptr_en_i, io_wr_i, ds_wr_i} = '0;
    ien_cmd_i = CSR_IEN_NONE;
    stk_op_i = CSR_STK_NONE;
    @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] d, input logic w16);
    wr_idx_i = i;
    wr_data_i = d;
    wr8_en_i = !w16;
    wr16_en_i = w16;
    fire();
  endtask

  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1;
    fire();
  endtask

  task automatic ptr_op(input csr_ptr_mode_t m, input logic [15:0] ea, input logic [15:0] pv);
    ptr_mode_i = m;
    ptr_en_i = 1;
    #1;
    `CHK("ptr addr", ea, ptr_addr_o)
    fire();
    `CHK("ptr value", pv, rd_word_o)
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("CHECK FAILED watchdog exp finish got hang");
    summarize();
  end

  initial begin
    logic [7:0]  e, v;
    logic [15:0] w, s;
    logic        t;
    repeat (5) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    `CHK("flags reset", STATUS_RESET, status_flags_o)
    `CHK("sp reset", LAST_DATA_MEMORY_ADDRESS, sp_o)
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      ds_addr_i = IO_DATA_BASE + 16'h003f;
      ds_wdata_i = v;
      ds_wr_i = i[0];
      if (!i[0]) io_wr(IO_STATUS_FLAGS, v);
      else fire();
      #1;
      `CHK("flags io", v, io_rdata_o)
      `CHK("flags ds", v, ds_rdata_o)
      `CHK("ien", v[7], global_ien_o)
    end
    for (int i = 0; i < 12; i++) begin
      op_a = i == 0 ? 8'h88 : i == 1 ? 8'h0f : 8'($random(seed));
      op_b = i == 0 ? 8'h88 : i == 1 ? 8'h01 : 8'($random(seed));
      alu_mask_i = i < 2 ? 8'h3f : 8'($random(seed)) & 8'h3f;
      alu_upd_i = 1;
      #1;
      e = exp_flags(status_flags_o, alu_mask_i, {alu_h_i, alu_v_i, alu_n_i, alu_z_i, alu_c_i});
      fire();
      `CHK("alu flags", e, status_flags_o)
    end
    irq_pending_i = 1;
    v = 8'($random(seed)) & 8'h7f;
    io_wr(IO_STATUS_FLAGS, v);
    for (int k = 0; k < 4; k++) begin
      ien_cmd_i = cmds[k];
      fire();
      `CHK("flags after ien", {k == 0 || k == 2, v[6:0]}, status_flags_o)
      `CHK("take ok", k == 0, irq_take_ok_o)
    end
    ien_cmd_i = CSR_IEN_RETURN;
    @(posedge clk_i);
    #1;
    `CHK("held after return", 1'b0, irq_take_ok_o)
    ien_cmd_i = CSR_IEN_NONE;
    instr_done_i = 1;
    fire();
    `CHK("released", 1'b1, irq_take_ok_o)
    irq_pending_i = 0;
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'($random(seed));
      wr(5'(i), {8'h00, mem[i]}, 1'b0);
    end
    for (int i = 0; i < 32; i++) begin
      rd_a_idx_i = 5'(i);
      rd_b_idx_i = 5'(31 - i);
      ds_addr_i = 16'(i);
      #1;
      `CHK("rd a", mem[i], rd_a_o)
      `CHK("rd b", mem[31 - i], rd_b_o)
      `CHK("ds reg", mem[i], ds_rdata_o)
    end
    ds_addr_i = 16'h0020;
    #1;
    `CHK("ds unmapped", 1'b0, ds_hit_o)
    for (int i = 0; i < 4; i++) begin
      bit_reg_i = 5'(i * 7);
      bit_sel_i = 3'($random(seed));
      t = mem[i * 7][bit_sel_i];
      bit_store_instruction_i = 1;
      fire();
      `CHK("t bit", t, status_flags_o[FLAG_T])
      bit_reg_i = 5'(i * 7 + 1);
      bit_sel_i = 3'($random(seed));
      mem[i * 7 + 1][bit_sel_i] = t;
      bit_load_instruction_i = 1;
      fire();
      rd_a_idx_i = bit_reg_i;
      #1;
      `CHK("bit load", mem[i * 7 + 1], rd_a_o)
    end
    for (int p = 26; p < 31; p += 2) begin
      w = 16'($random(seed));
      wr(5'(p), w, 1'b1);
      rd_a_idx_i = 5'(p);
      ds_addr_i = 16'(p + 1);
      #1;
      `CHK("pair word", w, rd_word_o)
      `CHK("pair high", w[15:8], ds_rdata_o)
      ptr_sel_i = 5'(p);
      ptr_disp_i = 6'($random(seed));
      ptr_op(CSR_PTR_DISP, w + 16'(ptr_disp_i), w);
      ptr_op(CSR_PTR_POSTINC, w, w + 16'h0001);
      ptr_op(CSR_PTR_PREDEC, w, w);
    end
    s = 16'h0100 + 16'($random(seed) & 32'h07ff);
    io_wr(IO_STACK_POINTER_LOW, s[7:0]);
    io_wr(IO_STACK_POINTER_HIGH, s[15:8]);
    `CHK("sp write", s, sp_o)
    `CHK("sp high read", s[15:8], io_rdata_o)
    for (int k = 0; k < 4; k++) begin
      stk_op_i = sops[k];
      #1;
      `CHK("stack addr", k < 2 ? s : s + 16'h0001, stk_addr_o)
      fire();
      s = s + sdel[k];
      `CHK("sp step", s, sp_o)
    end
    io_addr_i = 6'h3c;
    #1;
    `CHK("io unmapped", 1'b0, io_hit_o)
    summarize();
  end
endmodule
`default_nettype wire
